// ### core/pfe_pkg.sv
// Purpose: shared constants for the paged flash / eeprom access block
// Assumes: 10 MHz bus clock, 32-bit AHB-Lite register bus
// Notes: every offset, eeprom command and status field and timing count used by the logic lives here; map and guard bits are coded in pfe_top
package pfe_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int FLASH_MS_PER_KB = 60; // flash programming time per kilobyte
  localparam int FLASH_BYTES_PER_KB = 1024;
  // least time per byte, rounded up to whole cycles
  localparam int FLASH_BYTE_CYC = (FLASH_MS_PER_KB * 1000000 + FLASH_BYTES_PER_KB * CLK_PERIOD_NS - 1)
                                  / (FLASH_BYTES_PER_KB * CLK_PERIOD_NS);
  localparam int EE_WRITE_MS = 20; // one eeprom byte
  localparam int EE_WRITE_CYC = EE_WRITE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TMR_W = 18; // wide enough for the eeprom count

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_MAP_CTRL = 8'h00;
  localparam logic [7:0] OFS_GUARD = 8'h04;
  localparam logic [7:0] OFS_EE_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_FLASH_KEY = 8'h10;
  localparam logic [31:0] FLASH_KEY_1 = 32'h0000_00A5;
  localparam logic [31:0] FLASH_KEY_2 = 32'h0000_005A;

  // ==========================================================
  // field layouts
  localparam int EE_CMD_ADDR_LSB = 0; // cell index 8:0
  localparam int EE_CMD_DATA_LSB = 16; // byte 23:16
  localparam int ST_EE_BUSY = 0;
  localparam int ST_FL_BUSY = 1;
  localparam int ST_MAP = 2;
  localparam int ST_ARMED = 3;

  // ==========================================================
  // address map
  localparam logic [15:0] EE_BASE = 16'hAE00;
  localparam logic [15:0] EE_LAST = 16'hAFFF;
  localparam int EE_AW = 9;
  localparam int EE_BYTES = 512;
  // block boundaries at 32, 96, 224: blocks of 32, 64, 128, 288 bytes
  localparam logic [8:0] EE_BLK1 = 9'h020;
  localparam logic [8:0] EE_BLK2 = 9'h060;
  localparam logic [8:0] EE_BLK3 = 9'h0E0;
  localparam logic [15:0] COMMON_BASE = 16'h8000; // below this the page applies

  // ==========================================================
  // flash programming sequence
  typedef enum logic [1:0] {
    PFE_FL_IDLE = 2'b00,
    PFE_FL_KEY1 = 2'b01,
    PFE_FL_ARMED = 2'b11,
    PFE_FL_PROG = 2'b10
  } pfe_fl_state_e;
endpackage

// ### core/pfe_busy_timer.sv
// Purpose: one-shot busy timer for programming operations
// Assumes: start only honoured while idle
// Notes: busy holds for exactly LOAD clock-enabled cycles
`timescale 1ns/1ps
module pfe_busy_timer #(
  parameter int W = 18,
  parameter logic [W-1:0] LOAD = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  output logic busy
);
  // ==========================================================
  // countdown
  logic [W-1:0] cnt_reg; // cycles still to run
  logic [W-1:0] cnt_next;

  // load on start, count down to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end else if (start) begin
      cnt_next = LOAD;
    end
  end

  // frozen whenever the clock enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

  assign busy = (cnt_reg != '0);
endmodule

// ### core/pfe_top.sv
// Purpose: page decoder, flash write guard and eeprom programming engine
// Assumes: memory port driven by the core on clk; registers over AHB-Lite
// Notes: flash and ram arrays sit outside; only the eeprom is held here
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module pfe_top #(
  parameter int EE_PROG_CYCLES = pfe_pkg::EE_WRITE_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // processor memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [5:0] mem_page,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_wait,
  output logic [7:0] mem_rdata,
  output logic flash_sel,
  output logic flash_we,
  output logic ram_sel,
  output logic ram_we
);
  // ==========================================================
  // reset release
  logic rst_meta_reg; // first stage, read only by the second
  logic rst_n; // synchronised reset used everywhere else

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ==========================================================
  // page decode
  logic paged; // window below common space
  logic grp_a; // pages 01-03, 18-1F
  logic grp_b; // pages 04-06, 10-17
  logic map_reg; // 1 = download map
  logic ee_hit; // eeprom in common space
  logic [8:0] ee_idx;

  always_comb begin
    paged = (mem_addr < pfe_pkg::COMMON_BASE);
    grp_a = (mem_page >= 6'h01 && mem_page <= 6'h03) || (mem_page >= 6'h18 && mem_page <= 6'h1F);
    grp_b = (mem_page >= 6'h04 && mem_page <= 6'h06) || (mem_page >= 6'h10 && mem_page <= 6'h17);
    ee_hit = mem_req && mem_addr >= pfe_pkg::EE_BASE && mem_addr <= pfe_pkg::EE_LAST;
    ee_idx = mem_addr[pfe_pkg::EE_AW-1:0];
    // pages outside both groups are left to other decoders
    flash_sel = mem_req && paged && (map_reg ? grp_a : grp_b);
    ram_sel = mem_req && paged && (map_reg ? grp_b : grp_a);
  end

  // ==========================================================
  // ahb-lite slave, zero wait states, always okay
  logic dp_wr_reg; // write data phase pending
  logic [7:0] dp_addr_reg;
  logic [31:0] hrdata_reg;
  logic dp_wr_next;
  logic [7:0] dp_addr_next;
  logic [31:0] hrdata_next;
  logic ap_take; // address phase accepted this edge
  logic [3:0] guard_reg; // eeprom_block_guard
  logic [31:0] status_w;
  pfe_pkg::pfe_fl_state_e fl_state_reg;
  logic ee_busy;
  logic fl_busy;

  assign ap_take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // status word shows the engine's own state
  always_comb begin
    status_w = '0;
    status_w[pfe_pkg::ST_EE_BUSY] = ee_busy;
    status_w[pfe_pkg::ST_FL_BUSY] = fl_busy;
    status_w[pfe_pkg::ST_MAP] = map_reg;
    status_w[pfe_pkg::ST_ARMED] = (fl_state_reg == pfe_pkg::PFE_FL_ARMED);
  end

  // read data is registered in the address phase so it stands in the data phase
  always_comb begin
    dp_wr_next = ap_take && hwrite;
    dp_addr_next = ap_take ? haddr[7:0] : dp_addr_reg;
    hrdata_next = hrdata_reg;
    if (ap_take && !hwrite) begin
      case (haddr[7:0])
        pfe_pkg::OFS_MAP_CTRL: hrdata_next = {31'h0000_0000, map_reg};
        pfe_pkg::OFS_GUARD: hrdata_next = {28'h000_0000, guard_reg};
        pfe_pkg::OFS_STATUS: hrdata_next = status_w;
        default: hrdata_next = 32'h0000_0000; // unmapped and write-only read zero
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      dp_wr_reg <= dp_wr_next;
      dp_addr_reg <= dp_addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  logic map_wr; // register writes in the data phase
  logic guard_wr;
  logic ee_cmd_wr;
  logic key_wr;
  assign map_wr = dp_wr_reg && dp_addr_reg == pfe_pkg::OFS_MAP_CTRL;
  assign guard_wr = dp_wr_reg && dp_addr_reg == pfe_pkg::OFS_GUARD;
  assign ee_cmd_wr = dp_wr_reg && dp_addr_reg == pfe_pkg::OFS_EE_CMD;
  assign key_wr = dp_wr_reg && dp_addr_reg == pfe_pkg::OFS_FLASH_KEY;

  // ==========================================================
  // map select and guard bits
  logic map_next;
  logic [3:0] guard_next;

  always_comb begin
    map_next = map_wr ? hwdata[0] : map_reg;
    guard_next = guard_wr ? hwdata[3:0] : guard_reg;
  end

  // run map out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_reg <= 1'b0;
      guard_reg <= 4'h0;
    end else if (ce) begin
      map_reg <= map_next;
      guard_reg <= guard_next;
    end
  end

  // ==========================================================
  // flash programming guard: key pair arms one write
  pfe_pkg::pfe_fl_state_e fl_state_next;
  logic fl_start;

  // a stray store cannot match the key pair, so code survives a lost core
  always_comb begin
    fl_state_next = fl_state_reg;
    flash_we = 1'b0;
    fl_start = 1'b0;
    case (fl_state_reg)
      pfe_pkg::PFE_FL_IDLE: begin
        if (key_wr && hwdata == pfe_pkg::FLASH_KEY_1) begin
          fl_state_next = pfe_pkg::PFE_FL_KEY1;
        end
      end
      pfe_pkg::PFE_FL_KEY1: begin
        if (key_wr) begin
          fl_state_next = (hwdata == pfe_pkg::FLASH_KEY_2) ? pfe_pkg::PFE_FL_ARMED : pfe_pkg::PFE_FL_IDLE;
        end
      end
      pfe_pkg::PFE_FL_ARMED: begin
        // gated by ce so a frozen cycle cannot repeat the one permitted write
        if (ce && flash_sel && mem_we) begin
          flash_we = 1'b1;
          fl_start = 1'b1;
          fl_state_next = pfe_pkg::PFE_FL_PROG;
        end else if (key_wr) begin
          fl_state_next = pfe_pkg::PFE_FL_IDLE; // any key write disarms
        end
      end
      pfe_pkg::PFE_FL_PROG: begin
        if (!fl_busy && !fl_start) begin
          fl_state_next = pfe_pkg::PFE_FL_IDLE;
        end
      end
      default: fl_state_next = pfe_pkg::PFE_FL_IDLE;
    endcase
    ram_we = ram_sel && mem_we;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fl_state_reg <= pfe_pkg::PFE_FL_IDLE;
    end else if (ce) begin
      fl_state_reg <= fl_state_next;
    end
  end

  // per-byte flash time; software must poll until it clears
  pfe_busy_timer #(
    .W(pfe_pkg::TMR_W),
    .LOAD(pfe_pkg::TMR_W'(pfe_pkg::FLASH_BYTE_CYC))
  ) u_fl_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(fl_start),
    .busy(fl_busy)
  );

  // ==========================================================
  // eeprom array and programming
  logic [7:0] ee_mem [pfe_pkg::EE_BYTES]; // cells held in flip-flops
  logic [8:0] cmd_idx;
  logic [7:0] cmd_data;
  logic blk_guarded;
  logic ee_start;
  logic [7:0] mem_rdata_reg;
  logic [7:0] mem_rdata_next;

  // decide which guard block the addressed cell belongs to
  always_comb begin
    cmd_idx = hwdata[pfe_pkg::EE_CMD_ADDR_LSB +: pfe_pkg::EE_AW];
    cmd_data = hwdata[pfe_pkg::EE_CMD_DATA_LSB +: 8];
    if (cmd_idx < pfe_pkg::EE_BLK1) begin
      blk_guarded = guard_reg[0];
    end else if (cmd_idx < pfe_pkg::EE_BLK2) begin
      blk_guarded = guard_reg[1];
    end else if (cmd_idx < pfe_pkg::EE_BLK3) begin
      blk_guarded = guard_reg[2];
    end else begin
      blk_guarded = guard_reg[3];
    end
    // a write while busy is dropped too: one cell at a time
    ee_start = ee_cmd_wr && !ee_busy && !blk_guarded;
    // only eeprom reads stall while a byte programs; reads outside the eeprom window, vector fetches included, are not held
    mem_wait = ee_hit && !mem_we && ee_busy;
    mem_rdata_next = (ee_hit && !mem_we && !ee_busy) ? ee_mem[ee_idx] : mem_rdata_reg;
  end

  // cell content changes at start; reads are blocked until done anyway
  always_ff @(posedge clk) begin
    if (ce && rst_n && ee_start) begin
      ee_mem[cmd_idx] <= cmd_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata_reg <= 8'h00;
    end else if (ce) begin
      mem_rdata_reg <= mem_rdata_next;
    end
  end
  assign mem_rdata = mem_rdata_reg;

  pfe_busy_timer #(
    .W(pfe_pkg::TMR_W),
    .LOAD(pfe_pkg::TMR_W'(EE_PROG_CYCLES))
  ) u_ee_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(ee_start),
    .busy(ee_busy)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_run_map;
    (!map_reg && mem_req && paged && grp_b) |-> (flash_sel && !ram_sel);
  endproperty
  a_run_map: assert property (p_run_map) else $error("run map flash page misrouted");

  property p_dl_map;
    (map_reg && mem_req && paged && grp_a) |-> (flash_sel && !ram_sel);
  endproperty
  a_dl_map: assert property (p_dl_map) else $error("download map flash page misrouted");

  property p_flash_guard;
    flash_we |-> ##1 (fl_state_reg == pfe_pkg::PFE_FL_PROG && fl_busy) ##1 !flash_we;
  endproperty
  a_flash_guard: assert property (p_flash_guard) else $error("flash write outside armed sequence");

  property p_fl_busy;
    $rose(fl_busy) |-> fl_busy [*8] ##[1:600] !fl_busy;
  endproperty
  a_fl_busy: assert property (p_fl_busy) else $error("flash busy time wrong");

  property p_ee_read;
    (ee_hit && !mem_we && !ee_busy && ce) |-> !mem_wait ##1 (mem_rdata === $past(ee_mem[ee_idx]));
  endproperty
  a_ee_read: assert property (p_ee_read) else $error("eeprom read not served");

  property p_ee_time;
    $rose(ee_busy) |-> ee_busy [*8];
  endproperty
  a_ee_time: assert property (p_ee_time) else $error("eeprom busy too short");

  property p_ee_block;
    (ee_hit && !mem_we && ee_busy) |-> mem_wait;
  endproperty
  a_ee_block: assert property (p_ee_block) else $error("eeprom read during programming");

  property p_guarded;
    (ee_cmd_wr && blk_guarded && !ee_busy) |=> !ee_busy;
  endproperty
  a_guarded: assert property (p_guarded) else $error("guarded eeprom write started");

  property p_map_hold;
    (map_reg != $past(map_reg)) |-> $past(map_wr);
  endproperty
  a_map_hold: assert property (p_map_hold) else $error("map changed without a write");

  c_flash_prog: cover property (flash_we);
  c_ee_prog: cover property (ee_start);
  c_ee_stall: cover property (mem_wait);
  c_dl_map: cover property ($rose(map_reg));
endmodule

// ### test/pfe_core_model.sv
// Purpose: processor core model on the memory port
// Assumes: requests start just after a rising edge
// Notes: released address lines show the inverse of their last value; drop flips the data lines too
`timescale 1ns/1ps
module pfe_core_model (
  input wire logic clk,
  output logic mem_req,
  output logic mem_we,
  output logic [5:0] mem_page,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_wait,
  input wire logic [7:0] mem_rdata
);
  logic irq_masked; // interrupts deferred while a byte programs
  // idle port at time zero
  initial begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_page = 6'h00;
    mem_addr = 16'h0000;
    mem_wdata = 8'h00;
    irq_masked = 1'b0;
  end
  // ==========================================================
  // bus cycles
  // present one request, return once it has settled
  task automatic put(input logic we, input logic [5:0] pg, input logic [15:0] a);
    @(posedge clk);
    mem_req <= 1'b1;
    mem_we <= we;
    mem_page <= pg;
    mem_addr <= a;
    mem_wdata <= a[7:0];
    #1;
  endtask
  // flipped lines keep a stale value from passing for a live one
  task automatic drop();
    @(posedge clk);
    mem_req <= 1'b0;
    mem_addr <= ~mem_addr;
    mem_wdata <= ~mem_wdata;
  endtask
  // the read is held while the eeprom programs
  task automatic read(input logic [15:0] a, output logic [7:0] d, output int waits);
    put(1'b0, 6'h00, a);
    waits = 0;
    @(posedge clk);
    while (mem_wait !== 1'b0 && waits < 1000) begin
      waits++;
      @(posedge clk);
    end
    mem_req <= 1'b0;
    mem_addr <= ~mem_addr;
    #1;
    d = mem_rdata;
  endtask
  // global interrupt mask around each eeprom byte
  task automatic mask(input logic on);
    irq_masked = on;
  endtask
endmodule

// ### test/paged_flash_eeprom_access_tb_top.sv
// Purpose: self-checking bench for page decode, flash guard and eeprom engine
// Assumes: short eeprom programming count, one slave on the bus
// Notes: registers over AHB-Lite, memory traffic from the core model
`timescale 1ns/1ps
module paged_flash_eeprom_access_tb_top;
  localparam int EE_N = 20; // shortened eeprom count
  localparam int FL_N = pfe_pkg::FLASH_BYTE_CYC;
  localparam int LIMIT = 20000; // cycles, well above the expected run
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, mem_wait, flash_sel, flash_we, ram_sel, ram_we;
  logic [31:0] hrdata;
  logic mem_req, mem_we;
  logic [5:0] mem_page;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, d;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int w;
  // boundary cells of the four guard blocks and their values
  logic [8:0] lo [4] = '{9'h000, 9'h020, 9'h060, 9'h0E0};
  logic [8:0] hi [4] = '{9'h01F, 9'h05F, 9'h0DF, 9'h1FF};
  logic [7:0] vl [4] = '{8'h11, 8'h12, 8'h13, 8'h14};
  logic [7:0] vh [4] = '{8'h21, 8'h22, 8'h23, 8'h24};

  // ==========================================================
  // design and core model
  pfe_top #(.EE_PROG_CYCLES(EE_N)) i_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_page(mem_page), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wait(mem_wait),
    .mem_rdata(mem_rdata), .flash_sel(flash_sel), .flash_we(flash_we), .ram_sel(ram_sel), .ram_we(ram_we));
  pfe_core_model u_core (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_page(mem_page),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wait(mem_wait), .mem_rdata(mem_rdata));

  // ==========================================================
  // clock and hang guard
  initial begin
    forever #50 clk = ~clk;
  end
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      finish_test();
    end
  end

  // ==========================================================
  // reporting
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  // ==========================================================
  // bus cycles: address phase, then data phase
  task automatic ahb(input logic is_wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rv);
    @(posedge clk);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= is_wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    ahb(1'b1, a, v, x);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    chk_word(x, e);
  endtask
  // poll a busy bit until clear and bound how long it stood
  task automatic wait_clear(input int b, input int n);
    logic [31:0] v;
    int t0;
    t0 = cyc;
    do ahb(1'b0, pfe_pkg::OFS_STATUS, 32'h0000_0000, v); while (v[b] === 1'b1);
    chk_bit(cyc - t0 >= n - 1 && cyc - t0 <= n + 8, 1'b1);
  endtask

  // ==========================================================
  // scenario helpers
  // selects on every page for one map
  task automatic decode_all(input logic dl);
    logic ga, gb;
    for (int p = 0; p < 64; p++) begin
      ga = (p >= 4 && p <= 6) || (p >= 16 && p <= 23);
      gb = (p >= 1 && p <= 3) || (p >= 24 && p <= 31);
      u_core.put(1'b0, p[5:0], 16'h1234);
      chk_bit(flash_sel, dl ? gb : ga);
      chk_bit(ram_sel, dl ? ga : gb);
    end
    u_core.drop();
  endtask
  // kernel style store: compare first, mask interrupts around the write
  task automatic ee_store(input logic [8:0] idx, input logic [7:0] v, input logic run);
    logic [7:0] cur;
    int n;
    u_core.read(pfe_pkg::EE_BASE + {7'h00, idx}, cur, n);
    if (cur === v) return;
    u_core.mask(1'b1);
    wr(pfe_pkg::OFS_EE_CMD, {8'h00, v, 7'h00, idx});
    if (run) wait_clear(pfe_pkg::ST_EE_BUSY, EE_N);
    else rchk(pfe_pkg::OFS_STATUS, 32'h0000_0000);
    u_core.mask(1'b0);
  endtask
  task automatic chk_ee(input logic [8:0] idx, input logic [7:0] e);
    logic [7:0] v;
    int n;
    u_core.read(pfe_pkg::EE_BASE + {7'h00, idx}, v, n);
    chk_word({24'h00_0000, v}, {24'h00_0000, e});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset state; an unmapped write must not touch the map
    wr(8'h20, 32'h0000_0001);
    rchk(pfe_pkg::OFS_STATUS, 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
    rchk(pfe_pkg::OFS_GUARD, 32'h0000_0000);
    chk_bit(hresp, 1'b0);
    decode_all(1'b0);
    // plain stores: ram takes them, flash never does
    u_core.put(1'b1, 6'h04, 16'h0100);
    chk_bit(flash_we, 1'b0);
    u_core.put(1'b1, 6'h18, 16'h0100);
    chk_bit(ram_we, 1'b1);
    // a wrong second key leaves flash unarmed
    wr(pfe_pkg::OFS_FLASH_KEY, pfe_pkg::FLASH_KEY_1);
    wr(pfe_pkg::OFS_FLASH_KEY, 32'h0000_0011);
    rchk(pfe_pkg::OFS_STATUS, 32'h0000_0000);
    u_core.put(1'b1, 6'h04, 16'h0100);
    chk_bit(flash_we, 1'b0);
    // stage one byte in common ram, then the download order
    u_core.put(1'b1, 6'h00, 16'hB200);
    chk_bit(flash_sel | ram_sel, 1'b0);
    u_core.drop();
    wr(pfe_pkg::OFS_MAP_CTRL, 32'h0000_0001);
    rchk(pfe_pkg::OFS_STATUS, 32'h0000_0004);
    decode_all(1'b1);
    u_core.put(1'b1, 6'h04, 16'h0100);
    chk_bit(ram_we, 1'b1);
    wr(pfe_pkg::OFS_FLASH_KEY, pfe_pkg::FLASH_KEY_1);
    wr(pfe_pkg::OFS_FLASH_KEY, pfe_pkg::FLASH_KEY_2);
    rchk(pfe_pkg::OFS_STATUS, 32'h0000_000C);
    u_core.put(1'b1, 6'h01, 16'h0100);
    chk_bit(flash_we, 1'b1);
    u_core.drop();
    wait_clear(pfe_pkg::ST_FL_BUSY, FL_N);
    rchk(pfe_pkg::OFS_STATUS, 32'h0000_0004);
    wr(pfe_pkg::OFS_MAP_CTRL, 32'h0000_0000);
    rchk(pfe_pkg::OFS_STATUS, 32'h0000_0000);
    // reads stall on any cell while a byte programs
    wr(pfe_pkg::OFS_EE_CMD, 32'h0077_0150);
    u_core.put(1'b0, 6'h00, 16'hAE10);
    chk_bit(mem_wait, 1'b1);
    u_core.drop();
    u_core.read(16'hAF50, d, w);
    chk_word({24'h00_0000, d}, 32'h0000_0077);
    chk_bit(w >= EE_N - 8 && w <= EE_N, 1'b1);
    // block boundaries: guarded cells hold, neighbours stay writable
    for (int b = 0; b < 4; b++) begin
      ee_store(lo[b], vl[b], 1'b1);
      ee_store(hi[b], vh[b], 1'b1);
    end
    for (int b = 0; b < 4; b++) begin
      wr(pfe_pkg::OFS_GUARD, 32'h0000_0001 << b);
      rchk(pfe_pkg::OFS_GUARD, 32'h0000_0001 << b);
      ee_store(lo[b], 8'hC3, 1'b0);
      ee_store(hi[b], 8'hC3, 1'b0);
      chk_ee(lo[b], vl[b]);
      chk_ee(hi[b], vh[b]);
      vh[(b + 3) % 4] = ~vh[(b + 3) % 4];
      ee_store(hi[(b + 3) % 4], vh[(b + 3) % 4], 1'b1);
      vl[(b + 1) % 4] = ~vl[(b + 1) % 4];
      ee_store(lo[(b + 1) % 4], vl[(b + 1) % 4], 1'b1);
      chk_ee(lo[(b + 1) % 4], vl[(b + 1) % 4]);
    end
    // advised setting: first three blocks guarded, last one open
    wr(pfe_pkg::OFS_GUARD, 32'h0000_0007);
    ee_store(9'h0C0, 8'h5A, 1'b0);
    ee_store(9'h140, 8'hA5, 1'b1);
    chk_ee(9'h140, 8'hA5);
    // a low clock enable freezes every register but the reset synchroniser, so this map write is lost
    ce <= 1'b0;
    wr(pfe_pkg::OFS_MAP_CTRL, 32'h0000_0001);
    ce <= 1'b1;
    rchk(pfe_pkg::OFS_STATUS, 32'h0000_0000);
    finish_test();
  end
endmodule
